/* core/sar_ctrl_pkg.sv */
// constants, field layout and carrier types of the converter control block
// assumes one 100 MHz clock and an active-low asynchronous reset
package sar_ctrl_pkg;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_RESULT = 8'h00;
	localparam logic [7:0] OFF_CTRL   = 8'h20;
	localparam logic [7:0] OFF_CHEN   = 8'h24;
	localparam logic [7:0] OFF_CMP0   = 8'h28;
	localparam logic [7:0] OFF_CMP1   = 8'h2c;
	localparam logic [7:0] OFF_STAT   = 8'h30;
	localparam logic [7:0] OFF_CLKCFG = 8'h34;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int RES_OVR      = 16;
	localparam int RES_VALID    = 17;
	localparam int CTRL_POWER   = 0;
	localparam int CTRL_DONE_IE = 1;
	localparam int CTRL_EDGE    = 6;
	localparam int CTRL_TRIG_EN = 8;
	localparam int CTRL_GO      = 11;
	localparam int CHEN_CH7SEL  = 8;
	localparam int CMP_EN       = 0;
	localparam int CMP_IE       = 1;
	localparam int CMP_COND     = 2;
	localparam int CMP_CH_LO    = 3;
	localparam int CMP_LIM_LO   = 8;
	localparam int CMP_THR_LO   = 16;
	localparam int STAT_DONE    = 0;
	localparam int STAT_COMPARE_FLAG_A   = 1;
	localparam int STAT_COMPARE_FLAG_B   = 2;
	localparam int STAT_BUSY    = 3;
	localparam int STAT_CH_LO   = 4;
	localparam int STAT_VALID   = 8;
	localparam int STAT_OVR     = 16;
	localparam int CLK_SEL_LO   = 2;
	localparam int CLK_DIV_LO   = 16;

	// --------------------------------------------------------------
	// reset values and counts
	// --------------------------------------------------------------
	localparam logic [31:0] REG_RESET       = 32'h0;
	localparam logic [7:0]  DEGLITCH_CYCLES = 8'h04;

	// --------------------------------------------------------------
	// carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic       power_en;
		logic       convert;
		logic [2:0] channel;
		logic       bandgap_sel;
		logic       adc_clk;
	} core_ctrl_t;

	typedef struct packed {
		logic [9:0] thr;
		logic [3:0] lim;
		logic [2:0] ch;
		logic       cond;
		logic       ie;
		logic       en;
	} cmp_cfg_t;

	typedef enum logic {IDLE, CONVERT} conv_state_t;

endpackage : sar_ctrl_pkg

/* core/trig_deglitch.sv */
// deglitch filter for the external trigger pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/10ps
module trig_deglitch
	import sar_ctrl_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic pin_in,
	output logic      rise_q,
	output logic      fall_q
);

	logic       s1_q;
	logic       s2_q;
	logic       lvl_q;
	logic       armed_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	wire        accept;

	// --------------------------------------------------------------
	// synchroniser and stability counter
	// --------------------------------------------------------------
	assign accept = (s2_q != lvl_q) && (cnt_q == DEGLITCH_CYCLES - 8'h01);
	assign cnt_d  = (s2_q == lvl_q || accept) ? 8'h00 : cnt_q + 8'h01;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			lvl_q   <= 1'b0;
			armed_q <= 1'b0;
			cnt_q   <= 8'h00;
			rise_q  <= 1'b0;
			fall_q  <= 1'b0;
		end else begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			cnt_q   <= cnt_d;
			armed_q <= armed_q | accept | (s2_q == lvl_q);
			if (accept)
				lvl_q <= s2_q;
			rise_q  <= accept & armed_q & s2_q;
			fall_q  <= accept & armed_q & ~s2_q;
		end
	end

	property p_rise_stable;
		@(posedge sys_clk) disable iff (!nrst)
		rise_q |-> $past(s2_q, 1) && $past(s2_q, 2) && $past(s2_q, 3)
			&& $past(s2_q, 4) && !$past(lvl_q, 1);
	endproperty
	a_rise_stable: assert property (p_rise_stable)
		else $error("rise accepted without four stable high cycles");

endmodule : trig_deglitch

/* core/sar_ctrl.sv */
// sequencing control of a 10-bit successive-approximation converter
// assumes an analog core that converts while convert is high and raises
// core_done, holding core_result steady, until convert drops
`timescale 1ns/10ps
module sar_ctrl
	import sar_ctrl_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire reg_req_t   bus_req,
	output logic [31:0]     bus_rdata,
	input  wire logic       ext_trigger_pin,
	input  wire logic       core_done,
	input  wire logic [9:0] core_result,
	output core_ctrl_t      core_ctrl,
	output logic            irq
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic        converter_power_enable_q;
	logic        done_irq_enable_q;
	logic        trigger_edge_select_q;
	logic        ext_trigger_enable_q;
	logic        conversion_go_q;
	logic        conversion_go_d;
	logic [7:0]  channel_enable_bits_q;
	logic        ch7_source_select_q;
	cmp_cfg_t    cmp_cfg_q [2];
	logic [4:0]  match_cnt_q [2];
	logic [4:0]  match_cnt_d [2];
	logic [1:0]  cmp_flag_q;
	logic [1:0]  cmp_hit;
	logic        conversion_done_flag_q;
	logic [9:0]  result_field_q;
	logic        valid_q;
	logic        ovr_q;
	conv_state_t state_q;
	logic [2:0]  cur_ch_q;
	logic [1:0]  clk_sel_q;
	logic [7:0]  clk_div_q;
	logic [2:0]  pre_cnt_q;
	logic [7:0]  div_cnt_q;
	logic        adc_clk_q;
	logic        done_s1_q;
	logic        done_s2_q;
	logic        done_s3_q;
	logic [9:0]  res_s1_q;
	logic [9:0]  res_s2_q;
	logic [31:0] rdata_q;
	logic        irq_q;
	core_ctrl_t  core_q;
	logic        trig_rise;
	logic        trig_fall;

	// --------------------------------------------------------------
	// functions
	// --------------------------------------------------------------
	function automatic logic [2:0] lowest_ch(input logic [7:0] en);
		logic [2:0] c;
		c = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (en[i])
				c = 3'(i);
		end
		return c;
	endfunction : lowest_ch

	function automatic logic cmp_match(input cmp_cfg_t cfg,
	                                   input logic [9:0] res);
		return cfg.cond ? (res >= cfg.thr) : (res < cfg.thr);
	endfunction : cmp_match

	function automatic cmp_cfg_t cmp_unpack(input logic [31:0] w);
		cmp_cfg_t c;
		c.thr  = w[CMP_THR_LO +: 10];
		c.lim  = w[CMP_LIM_LO +: 4];
		c.ch   = w[CMP_CH_LO +: 3];
		c.cond = w[CMP_COND];
		c.ie   = w[CMP_IE];
		c.en   = w[CMP_EN];
		return c;
	endfunction : cmp_unpack

	function automatic logic [31:0] cmp_pack(input cmp_cfg_t c);
		logic [31:0] w;
		w = 32'h0;
		w[CMP_THR_LO +: 10] = c.thr;
		w[CMP_LIM_LO +: 4]  = c.lim;
		w[CMP_CH_LO +: 3]   = c.ch;
		w[CMP_COND]         = c.cond;
		w[CMP_IE]           = c.ie;
		w[CMP_EN]           = c.en;
		return w;
	endfunction : cmp_pack

	// --------------------------------------------------------------
	// bus decode
	// --------------------------------------------------------------
	wire wr_ctrl   = bus_req.wr && bus_req.addr == OFF_CTRL;
	wire wr_chen   = bus_req.wr && bus_req.addr == OFF_CHEN;
	wire wr_cmp0   = bus_req.wr && bus_req.addr == OFF_CMP0;
	wire wr_cmp1   = bus_req.wr && bus_req.addr == OFF_CMP1;
	wire wr_stat   = bus_req.wr && bus_req.addr == OFF_STAT;
	wire wr_clk    = bus_req.wr && bus_req.addr == OFF_CLKCFG;
	wire rd_result = bus_req.rd && bus_req.addr == OFF_RESULT;
	wire [2:0] next_ch = lowest_ch(channel_enable_bits_q);
	wire [2:0] stat_ch = (state_q == CONVERT && conversion_go_q) ? cur_ch_q
	                                                            : next_ch;

	// --------------------------------------------------------------
	// conversion sequencing
	// --------------------------------------------------------------
	wire done_edge = done_s2_q & ~done_s3_q;
	wire conv_end  = (state_q == CONVERT) && conversion_go_q && done_edge;
	wire trig_edge = trigger_edge_select_q ? trig_rise : trig_fall;
	wire trig_hit  = ext_trigger_enable_q && trig_edge &&
	                 state_q == IDLE && !conversion_go_q;
	wire power_d   = wr_ctrl ? bus_req.wdata[CTRL_POWER]
	                         : converter_power_enable_q;

	always_comb begin
		conversion_go_d = conversion_go_q;
		if (conv_end)
			conversion_go_d = 1'b0;
		if (wr_ctrl)
			conversion_go_d = bus_req.wdata[CTRL_GO];
		if (trig_hit)
			conversion_go_d = 1'b1;
		if (!power_d)
			conversion_go_d = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q  <= IDLE;
			cur_ch_q <= 3'h0;
		end else begin
			case (state_q)
				IDLE: begin
					if (conversion_go_q) begin
						state_q  <= CONVERT;
						cur_ch_q <= next_ch;
					end
				end
				CONVERT: begin
					if (!conversion_go_q || conv_end)
						state_q <= IDLE;
				end
				default: state_q <= IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// analog core handshake
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
			res_s1_q  <= 10'h000;
			res_s2_q  <= 10'h000;
			core_q    <= '0;
		end else begin
			done_s1_q            <= core_done;
			done_s2_q            <= done_s1_q;
			done_s3_q            <= done_s2_q;
			res_s1_q             <= core_result;
			res_s2_q             <= res_s1_q;
			core_q.power_en      <= converter_power_enable_q;
			core_q.convert       <= state_q == CONVERT && conversion_go_q;
			core_q.channel       <= cur_ch_q;
			core_q.bandgap_sel   <= ch7_source_select_q && cur_ch_q == 3'h7;
			core_q.adc_clk       <= adc_clk_q & converter_power_enable_q;
		end
	end

	// --------------------------------------------------------------
	// converter clock divider
	// --------------------------------------------------------------
	wire src_tick = (clk_sel_q == 2'h0) ? 1'b1 :
	                (clk_sel_q == 2'h1) ? pre_cnt_q[0] :
	                (clk_sel_q == 2'h2) ? &pre_cnt_q[1:0] : &pre_cnt_q;
	wire [7:0] div_cnt_d = (div_cnt_q >= clk_div_q) ? 8'h00
	                                                 : div_cnt_q + 8'h01;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pre_cnt_q <= 3'h0;
			div_cnt_q <= 8'h00;
			adc_clk_q <= 1'b0;
		end else begin
			pre_cnt_q <= pre_cnt_q + 3'h1;
			if (src_tick) begin
				div_cnt_q <= div_cnt_d;
				adc_clk_q <= div_cnt_d <= {1'b0, clk_div_q[7:1]};
			end
		end
	end

	// --------------------------------------------------------------
	// result register
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			result_field_q         <= 10'h000;
			valid_q                <= 1'b0;
			ovr_q                  <= 1'b0;
			conversion_done_flag_q <= 1'b0;
		end else begin
			if (conv_end) begin
				result_field_q <= res_s2_q;
				valid_q        <= 1'b1;
				ovr_q          <= valid_q & ~rd_result;
			end else if (rd_result) begin
				valid_q <= 1'b0;
				ovr_q   <= 1'b0;
			end
			if (conv_end)
				conversion_done_flag_q <= 1'b1;
			else if (wr_stat && bus_req.wdata[STAT_DONE])
				conversion_done_flag_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// compare units
	// --------------------------------------------------------------
	always_comb begin
		for (int u = 0; u < 2; u++) begin
			match_cnt_d[u] = match_cnt_q[u];
			cmp_hit[u]     = 1'b0;
			if (conv_end && cmp_cfg_q[u].en &&
			    cmp_cfg_q[u].ch == cur_ch_q) begin
				if (cmp_match(cmp_cfg_q[u], res_s2_q))
					match_cnt_d[u] = (match_cnt_q[u] == 5'h1f) ? 5'h1f
					               : match_cnt_q[u] + 5'h01;
				else
					match_cnt_d[u] = 5'h00;
				cmp_hit[u] = match_cnt_d[u] ==
				             {1'b0, cmp_cfg_q[u].lim} + 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int u = 0; u < 2; u++) begin
				cmp_cfg_q[u]   <= '0;
				match_cnt_q[u] <= 5'h00;
			end
			cmp_flag_q <= 2'h0;
		end else begin
			for (int u = 0; u < 2; u++) begin
				match_cnt_q[u] <= match_cnt_d[u];
				if (cmp_hit[u])
					cmp_flag_q[u] <= 1'b1;
				else if (wr_stat && bus_req.wdata[STAT_COMPARE_FLAG_A + u])
					cmp_flag_q[u] <= 1'b0;
			end
			if (wr_cmp0)
				cmp_cfg_q[0] <= cmp_unpack(bus_req.wdata);
			if (wr_cmp1)
				cmp_cfg_q[1] <= cmp_unpack(bus_req.wdata);
		end
	end

	// --------------------------------------------------------------
	// control registers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			converter_power_enable_q <= 1'b0;
			done_irq_enable_q        <= 1'b0;
			trigger_edge_select_q    <= 1'b0;
			ext_trigger_enable_q     <= 1'b0;
			conversion_go_q          <= 1'b0;
			channel_enable_bits_q    <= 8'h00;
			ch7_source_select_q      <= 1'b0;
			clk_sel_q                <= 2'h0;
			clk_div_q                <= 8'h00;
		end else begin
			conversion_go_q <= conversion_go_d;
			if (wr_ctrl) begin
				converter_power_enable_q <= bus_req.wdata[CTRL_POWER];
				done_irq_enable_q        <= bus_req.wdata[CTRL_DONE_IE];
				trigger_edge_select_q    <= bus_req.wdata[CTRL_EDGE];
				ext_trigger_enable_q     <= bus_req.wdata[CTRL_TRIG_EN];
			end
			if (wr_chen) begin
				channel_enable_bits_q <= bus_req.wdata[7:0];
				ch7_source_select_q   <= bus_req.wdata[CHEN_CH7SEL];
			end
			if (wr_clk) begin
				clk_sel_q <= bus_req.wdata[CLK_SEL_LO +: 2];
				clk_div_q <= bus_req.wdata[CLK_DIV_LO +: 8];
			end
		end
	end

	// --------------------------------------------------------------
	// read mux and interrupt
	// --------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = REG_RESET;
		case (bus_req.addr)
			OFF_RESULT: begin
				rd_mux[9:0]       = result_field_q;
				rd_mux[RES_OVR]   = ovr_q;
				rd_mux[RES_VALID] = valid_q;
			end
			OFF_CTRL: begin
				rd_mux[CTRL_POWER]   = converter_power_enable_q;
				rd_mux[CTRL_DONE_IE] = done_irq_enable_q;
				rd_mux[CTRL_EDGE]    = trigger_edge_select_q;
				rd_mux[CTRL_TRIG_EN] = ext_trigger_enable_q;
				rd_mux[CTRL_GO]      = conversion_go_q;
			end
			OFF_CHEN: begin
				rd_mux[7:0]         = channel_enable_bits_q;
				rd_mux[CHEN_CH7SEL] = ch7_source_select_q;
			end
			OFF_CMP0: rd_mux = cmp_pack(cmp_cfg_q[0]);
			OFF_CMP1: rd_mux = cmp_pack(cmp_cfg_q[1]);
			OFF_STAT: begin
				rd_mux[STAT_DONE]       = conversion_done_flag_q;
				rd_mux[STAT_COMPARE_FLAG_A]      = cmp_flag_q[0];
				rd_mux[STAT_COMPARE_FLAG_B]      = cmp_flag_q[1];
				rd_mux[STAT_BUSY]       = conversion_go_q;
				rd_mux[STAT_CH_LO +: 3] = stat_ch;
				rd_mux[STAT_VALID]      = valid_q;
				rd_mux[STAT_OVR]        = ovr_q;
			end
			OFF_CLKCFG: begin
				rd_mux[CLK_SEL_LO +: 2] = clk_sel_q;
				rd_mux[CLK_DIV_LO +: 8] = clk_div_q;
			end
			default: rd_mux = REG_RESET;
		endcase
	end

	wire irq_d = (conversion_done_flag_q & done_irq_enable_q) |
	             (cmp_flag_q[0] & cmp_cfg_q[0].ie) |
	             (cmp_flag_q[1] & cmp_cfg_q[1].ie);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= REG_RESET;
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= bus_req.rd ? rd_mux : REG_RESET;
			irq_q   <= irq_d;
		end
	end

	assign bus_rdata = rdata_q;
	assign irq       = irq_q;
	assign core_ctrl = core_q;

	trig_deglitch u_trig (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.pin_in  (ext_trigger_pin),
		.rise_q  (trig_rise),
		.fall_q  (trig_fall)
	);

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	property p_abort;
		@(posedge sys_clk) disable iff (!nrst)
		state_q == CONVERT && !conversion_go_q |=> state_q == IDLE
			&& $stable(result_field_q);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort did not return to idle cleanly");

	property p_load;
		@(posedge sys_clk) disable iff (!nrst)
		conv_end |=> result_field_q == $past(res_s2_q)
			&& conversion_done_flag_q && valid_q;
	endproperty
	a_load: assert property (p_load)
		else $error("result not loaded at conversion end");

	property p_go_clear;
		@(posedge sys_clk) disable iff (!nrst)
		conv_end && !wr_ctrl && !trig_hit |=> !conversion_go_q;
	endproperty
	a_go_clear: assert property (p_go_clear)
		else $error("start bit not cleared at conversion end");

	property p_valid_clear;
		@(posedge sys_clk) disable iff (!nrst)
		rd_result && !conv_end |=> !valid_q && !ovr_q;
	endproperty
	a_valid_clear: assert property (p_valid_clear)
		else $error("read did not clear valid and overrun");

	property p_overrun;
		@(posedge sys_clk) disable iff (!nrst)
		conv_end && valid_q && !rd_result |=> ovr_q;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun missed");

	property p_trig_off;
		@(posedge sys_clk) disable iff (!nrst)
		!ext_trigger_enable_q && !conversion_go_q && !wr_ctrl
			|=> !conversion_go_q;
	endproperty
	a_trig_off: assert property (p_trig_off)
		else $error("start set with trigger disabled");

	property p_prio;
		@(posedge sys_clk) disable iff (!nrst)
		state_q == IDLE && conversion_go_q |=> cur_ch_q == $past(next_ch);
	endproperty
	a_prio: assert property (p_prio)
		else $error("wrong channel chosen");

	property p_irq;
		@(posedge sys_clk) disable iff (!nrst)
		conversion_done_flag_q && done_irq_enable_q ##1 1'b1 |-> irq_q;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing for done flag");

endmodule : sar_ctrl

/* verif/adc_core_model.sv */
// analog converter core model for the control block
// assumes convert, power_en and bandgap_sel arrive registered
`timescale 1ns/10ps
module adc_core_model
	import sar_ctrl_pkg::*;
#(
	parameter logic [9:0] BG_CODE = 10'h155
)
(
	input  wire logic       sys_clk,
	input  wire core_ctrl_t core_ctrl,
	input  wire logic [9:0] level,
	input  wire logic [7:0] delay,
	output logic            core_done,
	output logic [9:0]      core_result
);
	logic [7:0] cnt_q;

	initial begin
		cnt_q = 8'h00;
		core_done = 1'b0;
		core_result = 10'h3ff;
	end

	// --------------------------------------------------------------
	// conversion
	// --------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!(core_ctrl.convert && core_ctrl.power_en)) begin
			cnt_q <= 8'h00;
			core_done <= 1'b0;
			core_result <= ~core_result;
		end else if (cnt_q == delay) begin
			core_done <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			core_result <= core_ctrl.bandgap_sel ? BG_CODE : level;
		end
	end
endmodule : adc_core_model

/* verif/sar_ctrl_test.sv */
// self-checking bench of the converter control block
// assumes the analog core model beside it
`timescale 1ns/10ps
module sar_ctrl_test;
	import sar_ctrl_pkg::*;

	localparam logic [9:0] BG = 10'h155;
	logic        sys_clk;
	logic        nrst;
	reg_req_t    bus_req;
	logic [31:0] bus_rdata;
	logic        pin;
	logic        core_done;
	logic [9:0]  core_result;
	core_ctrl_t  core_ctrl;
	logic        irq;
	logic [9:0]  level;
	logic [7:0]  delay;
	logic [31:0] rv;
	logic        a;
	int          failures;
	int          total_checks;
	int          cycles;
	logic [7:0]  offs [7] = '{OFF_RESULT, OFF_CTRL, OFF_CHEN, OFF_CMP0,
		OFF_CMP1, OFF_STAT, 8'h3c};

	sar_ctrl sar_ctrl_i (
		.sys_clk        (sys_clk),
		.nrst           (nrst),
		.bus_req        (bus_req),
		.bus_rdata      (bus_rdata),
		.ext_trigger_pin(pin),
		.core_done      (core_done),
		.core_result    (core_result),
		.core_ctrl      (core_ctrl),
		.irq            (irq)
	);

	adc_core_model #(.BG_CODE(BG)) adc_core_model_i (
		.sys_clk    (sys_clk),
		.core_ctrl  (core_ctrl),
		.level      (level),
		.delay      (delay),
		.core_done  (core_done),
		.core_result(core_result)
	);

	always #5 sys_clk = ~sys_clk;

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish;
		end
	end

	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req <= '0;
		@(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		bus_req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req <= '0;
		#1;
		d = bus_rdata;
		@(posedge sys_clk);
	endtask : rd

	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		rd(ad, rv);
		chk($sformatf("reg %h", ad), e, rv);
	endtask : rc

	task automatic irq_is(input logic e);
		#1;
		chk("irq", {31'h0, e}, {31'h0, irq});
		@(posedge sys_clk);
	endtask : irq_is

	task automatic wait_done;
		for (int i = 0; i < 80; i++) begin
			rd(OFF_STAT, rv);
			if (rv[STAT_DONE] === 1'b1)
				break;
		end
	endtask : wait_done

	task automatic go(input logic [31:0] c);
		wr(OFF_STAT, 32'h1);
		wr(OFF_CTRL, c);
		wait_done;
	endtask : go

	task automatic conv(input logic [31:0] c, input logic [31:0] e);
		go(c);
		rc(OFF_RESULT, e);
	endtask : conv

	// --------------------------------------------------------------
	// sequence
	// --------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		bus_req = '0;
		pin = 1'b0;
		level = 10'h2a5;
		delay = 8'd20;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		foreach (offs[i]) rc(offs[i], 32'h0);
		wr(OFF_CTRL, 32'h800);
		rc(OFF_CTRL, 32'h0);
		wr(OFF_CHEN, 32'h0c);
		wr(OFF_CMP0, 32'h0200_0117);
		wr(OFF_CMP1, 32'h0300_0011);
		wr(OFF_CTRL, 32'h803);
		rc(OFF_CTRL, 32'h803);
		rc(OFF_STAT, 32'h28);
		wait_done;
		rc(OFF_RESULT, 32'h2_02a5);
		rc(OFF_RESULT, 32'h2a5);
		rc(OFF_CTRL, 32'h3);
		rc(OFF_STAT, 32'h25);
		irq_is(1'b1);
		go(32'h803);
		go(32'h803);
		rc(OFF_STAT, 32'h1_0127);
		rc(OFF_RESULT, 32'h3_02a5);
		rc(OFF_RESULT, 32'h2a5);
		wr(OFF_STAT, 32'h0);
		rc(OFF_STAT, 32'h27);
		wr(OFF_STAT, 32'h1);
		irq_is(1'b1);
		wr(OFF_STAT, 32'h2);
		irq_is(1'b0);
		wr(OFF_STAT, 32'h4);
		rc(OFF_STAT, 32'h20);
		wr(OFF_CMP1, 32'h0300_0210);
		level <= 10'h100;
		conv(32'h803, 32'h2_0100);
		level <= 10'h2a5;
		conv(32'h803, 32'h2_02a5);
		rc(OFF_STAT, 32'h21);
		conv(32'h803, 32'h2_02a5);
		rc(OFF_STAT, 32'h23);
		level <= 10'h3c3;
		delay <= 8'd200;
		wr(OFF_STAT, 32'h3);
		wr(OFF_CTRL, 32'h803);
		wr(OFF_CTRL, 32'h3);
		repeat (4) @(posedge sys_clk);
		rc(OFF_STAT, 32'h20);
		rc(OFF_RESULT, 32'h2a5);
		delay <= 8'd20;
		wr(OFF_CLKCFG, 32'h002f_000c);
		wr(OFF_CHEN, 32'h180);
		conv(32'h803, {14'h0, 2'h2, 6'h0, BG});
		wr(OFF_CHEN, 32'h80);
		conv(32'h803, 32'h2_03c3);
		wr(OFF_STAT, 32'h1);
		wr(OFF_CTRL, 32'h141);
		pin <= 1'b1;
		wait_done;
		rc(OFF_RESULT, 32'h2_03c3);
		wr(OFF_STAT, 32'h1);
		wr(OFF_CTRL, 32'h101);
		pin <= 1'b0;
		wait_done;
		rc(OFF_RESULT, 32'h2_03c3);
		wr(OFF_STAT, 32'h1);
		wr(OFF_CTRL, 32'h041);
		pin <= 1'b1;
		repeat (30) @(posedge sys_clk);
		rc(OFF_STAT, 32'h70);
		wr(OFF_CTRL, 32'h101);
		pin <= 1'b0;
		repeat (2) @(posedge sys_clk);
		pin <= 1'b1;
		repeat (30) @(posedge sys_clk);
		rc(OFF_STAT, 32'h70);
		wr(OFF_CLKCFG, 32'h0001_0000);
		@(posedge sys_clk);
		#1;
		a = core_ctrl.adc_clk;
		@(posedge sys_clk);
		#1;
		chk("adc_clk", {31'h0, ~a}, {31'h0, core_ctrl.adc_clk});
		@(posedge sys_clk);
		#1;
		chk("adc_clk_period", {31'h0, a}, {31'h0, core_ctrl.adc_clk});
		@(posedge sys_clk);
		wr(OFF_CTRL, 32'h0);
		#1;
		chk("power_en", 32'h0, {31'h0, core_ctrl.power_en});
		chk("adc_clk_off", 32'h0, {31'h0, core_ctrl.adc_clk});
		tally_and_finish;
	end
endmodule : sar_ctrl_test
